//--- inc/fdpc_pkg.sv
package fdpc_pkg;
   // *****************************************************************
   // Clock and timing
   // *****************************************************************
   localparam int          CLK_HZ          = 10000000;
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          LOCK_LSB_MS     = 100;
   localparam int          LOCK_LSB_CYC    = CLK_HZ / 1000 * LOCK_LSB_MS;
   localparam int          BLANK_NS        = 1000;
   localparam int          BLANK_CYC       = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SLEW_FAST_NS    = 100;
   localparam int          SLEW_SLOW_NS    = 150;
   localparam int          SLEW_FAST_CYC   = (SLEW_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SLEW_SLOW_CYC   = (SLEW_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // *****************************************************************
   // Demand and PWM
   // *****************************************************************
   localparam int          DMD_W           = 9;
   localparam logic [8:0]  DMD_MAX         = 9'h1ff;
   localparam logic [8:0]  ADC_OFFSET      = 9'h002;
   localparam int          PWM_W           = 9;
   localparam int          DUTY_PERIOD_W   = 16;
   // *****************************************************************
   // Configuration fields
   // *****************************************************************
   localparam int          CFG_W           = 16;
   localparam int          CFG_SRC_BIT     = 3;
   localparam int          CFG_PP_LSB      = 4;
   localparam int          CFG_OVERVOLTAGE_LOCK_OPT_BIT  = 9;
   localparam int          CFG_SLEW_BIT    = 10;
   localparam int          CFG_SHORT_CLEAR_SEL_BIT  = 15;
   localparam logic [7:0]  LOCK_LATCH      = 8'hff;
   localparam logic [3:0]  RETRY_OFF       = 4'h0;
   localparam logic [15:0] PASSWORD_NONE   = 16'h0000;
   localparam logic [2:0]  PASSWORD_WORD   = 3'h7;
   // *****************************************************************
   // Protection state
   // *****************************************************************
   typedef enum logic [4:0] {
      FDPC_ST_STANDBY = 5'b00001,
      FDPC_ST_START   = 5'b00010,
      FDPC_ST_RUN     = 5'b00100,
      FDPC_ST_LOCKOUT = 5'b01000,
      FDPC_ST_HALT    = 5'b10000
   } fdpc_state_e;
endpackage : fdpc_pkg

//--- design/fdpc_duty_meas.sv
`timescale 1ns/10ps
module fdpc_duty_meas (
   // Clock and reset
   input  wire logic                           i_clk,
   input  wire logic                           i_rst_n,
   // Measured input
   input  wire logic                           i_level,
   // Result
   output logic [fdpc_pkg::DMD_W-1:0]          o_demand,
   output logic                                o_valid
);
   import fdpc_pkg::*;

   logic [DUTY_PERIOD_W-1:0] per_q, per_d, hi_q, hi_d;
   logic                     prev_q;
   logic [DMD_W-1:0]         dmd_q, dmd_d;
   logic                     vld_q, vld_d;
   logic [DUTY_PERIOD_W+DMD_W-1:0] scaled;

   // Divider is combinational; the update rate is one per input period, so area won over speed.
   always_comb begin
      per_d  = per_q;
      hi_d   = hi_q;
      dmd_d  = dmd_q;
      vld_d  = 1'b0;
      scaled = (DUTY_PERIOD_W+DMD_W)'(hi_q) * (DUTY_PERIOD_W+DMD_W)'(DMD_MAX);
      if (i_level && !prev_q) begin
         if (per_q != '0) begin
            dmd_d = DMD_W'(scaled / (DUTY_PERIOD_W+DMD_W)'(per_q));
         end
         vld_d = 1'b1;
         per_d = DUTY_PERIOD_W'(1);
         hi_d  = DUTY_PERIOD_W'(1);
      end else if (per_q != '1) begin
         per_d = per_q + DUTY_PERIOD_W'(1);
         if (i_level) begin
            hi_d = hi_q + DUTY_PERIOD_W'(1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         per_q  <= '0;
         hi_q   <= '0;
         prev_q <= 1'b0;
         dmd_q  <= '0;
         vld_q  <= 1'b0;
      end else begin
         per_q  <= per_d;
         hi_q   <= hi_d;
         prev_q <= i_level;
         dmd_q  <= dmd_d;
         vld_q  <= vld_d;
      end
   end

   assign o_demand = dmd_q;
   assign o_valid  = vld_q;
endmodule : fdpc_duty_meas

//--- design/fdpc_timer.sv
`timescale 1ns/10ps
module fdpc_timer (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // Control
   input  wire logic        i_start,
   input  wire logic        i_clear,
   input  wire logic [7:0]  i_ticks,
   // Status
   output logic             o_busy,
   output logic             o_done
);
   import fdpc_pkg::*;

   logic [23:0] cyc_q, cyc_d;
   logic [7:0]  tick_q, tick_d;
   logic        busy_q, busy_d, done_q, done_d;

   always_comb begin
      cyc_d  = cyc_q;
      tick_d = tick_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (i_clear) begin
         busy_d = 1'b0;
      end else if (i_start) begin
         busy_d = 1'b1;
         cyc_d  = '0;
         tick_d = i_ticks;
      end else if (busy_q) begin
         if (tick_q == 8'h00) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end else if (cyc_q == 24'(LOCK_LSB_CYC - 1)) begin
            cyc_d  = '0;
            tick_d = tick_q - 8'h01;
         end else begin
            cyc_d = cyc_q + 24'h000001;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cyc_q  <= '0;
         tick_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cyc_q  <= cyc_d;
         tick_q <= tick_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign o_busy = busy_q;
   assign o_done = done_q;
endmodule : fdpc_timer

//--- design/fdpc_ctrl.sv
`timescale 1ns/10ps
module fdpc_ctrl (
   // Clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   // Configuration
   input  wire logic [fdpc_pkg::CFG_W-1:0]  i_cfg,
   input  wire logic [7:0]                  i_lock_time,
   input  wire logic [3:0]                  i_retry_limit,
   input  wire logic                        i_overvoltage_disable,
   input  wire logic                        i_overvoltage_level_sel,
   input  wire logic                        i_standby_disable,
   input  wire logic [15:0]                 i_password,
   // Demand sources
   input  wire logic                        i_speed_demand_in,
   input  wire logic [8:0]                  i_adc_code,
   input  wire logic                        i_i2c_active,
   input  wire logic                        i_i2c_dmd_valid,
   input  wire logic [8:0]                  i_i2c_dmd,
   // Motor feedback
   input  wire logic                        i_elec_tick,
   input  wire logic                        i_startup_done,
   input  wire logic                        i_rotor_locked,
   // Protection inputs
   input  wire logic                        i_current_limit,
   input  wire logic                        i_short_circuit_trip,
   input  wire logic                        i_switch_on,
   input  wire logic                        i_ov_19v,
   input  wire logic                        i_ov_38v,
   input  wire logic                        i_thermal_trip,
   input  wire logic                        i_vbb_uv,
   input  wire logic                        i_pump_uv,
   // I2C data line drive
   input  wire logic                        i_i2c_sda_low,
   // Outputs
   output logic                             o_pwm,
   output logic                             o_drive_en,
   output logic                             o_slew_slow,
   output logic [1:0]                       o_slew_cycles,
   output logic                             o_speed_pulse_oe_n,
   output logic                             o_speed_pulse_out,
   output logic                             o_startup_oe_n,
   output logic                             o_startup_out,
   output logic                             o_fault_out_n,
   output logic                             o_standby,
   output logic                             o_readback_ok,
   output logic [8:0]                       o_demand
);
   import fdpc_pkg::*;

   // *****************************************************************
   // Demand selection
   // *****************************************************************
   logic [DMD_W-1:0] duty_dmd;
   logic             duty_vld;
   logic [DMD_W-1:0] dmd_q, dmd_d;
   logic [9:0]       adc_sum;

   fdpc_duty_meas u_meas (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_level (i_speed_demand_in),
      .o_demand(duty_dmd),
      .o_valid (duty_vld)
   );

   always_comb begin
      dmd_d   = dmd_q;
      adc_sum = {1'b0, i_adc_code} + {1'b0, ADC_OFFSET};
      if (i_i2c_active) begin
         if (i_i2c_dmd_valid) begin
            dmd_d = i_i2c_dmd;
         end
      end else if (i_cfg[CFG_SRC_BIT]) begin
         dmd_d = adc_sum[9] ? DMD_MAX : adc_sum[8:0];
      end else if (duty_vld) begin
         dmd_d = duty_dmd;
      end
   end

   // *****************************************************************
   // Protection state machine
   // *****************************************************************
   fdpc_state_e st_q, st_d;
   logic        short_lat_q, short_lat_d;
   logic        ov_lat_q, ov_lat_d;
   logic        tsd_lat_q, tsd_lat_d;
   logic        lock_lat_q, lock_lat_d;
   logic [3:0]  retry_q, retry_d;
   logic [3:0]  blank_q, blank_d;
   logic        cmd_off_q, cmd_off_d;
   logic        tmr_start, tmr_clear, tmr_busy, tmr_done;
   logic        sby_start, sby_busy, sby_done;
   logic        ov_raw, ov_follow, ov_lock, short_evt, event_any;
   logic        cmd_low;

   fdpc_timer u_lock_tmr (
      .i_clk  (i_clk),
      .i_rst_n(i_rst_n),
      .i_start(tmr_start),
      .i_clear(tmr_clear),
      .i_ticks(i_lock_time),
      .o_busy (tmr_busy),
      .o_done (tmr_done)
   );

   // Standby timer restarts on every high level, so only an unbroken low expires it.
   fdpc_timer u_sby_tmr (
      .i_clk  (i_clk),
      .i_rst_n(i_rst_n),
      .i_start(sby_start),
      .i_clear(1'b0),
      .i_ticks(i_lock_time),
      .o_busy (sby_busy),
      .o_done (sby_done)
   );

   always_comb begin
      cmd_low   = i_cfg[CFG_SRC_BIT] ? (i_adc_code == '0) : !i_speed_demand_in;
      ov_raw    = i_overvoltage_level_sel ? i_ov_38v : i_ov_19v;
      ov_follow = ov_raw && !i_cfg[CFG_OVERVOLTAGE_LOCK_OPT_BIT];
      ov_lock   = ov_raw && i_cfg[CFG_OVERVOLTAGE_LOCK_OPT_BIT] && !i_overvoltage_disable;
      short_evt = i_switch_on && i_short_circuit_trip && blank_q == 4'(BLANK_CYC);
      event_any = short_evt || ov_lock || i_thermal_trip || i_rotor_locked;
      sby_start = !cmd_low || (!sby_busy && !sby_done && st_q != FDPC_ST_STANDBY);
      st_d        = st_q;
      short_lat_d = short_lat_q;
      ov_lat_d    = ov_lat_q;
      tsd_lat_d   = tsd_lat_q;
      lock_lat_d  = lock_lat_q;
      retry_d     = retry_q;
      cmd_off_d   = cmd_off_q || cmd_low;
      tmr_start   = 1'b0;
      tmr_clear   = 1'b0;
      blank_d     = (i_switch_on && i_short_circuit_trip) ?
                    ((blank_q == 4'(BLANK_CYC)) ? blank_q : blank_q + 4'h1) : 4'h0;
      case (st_q)
         FDPC_ST_STANDBY: begin
            if (!cmd_low) begin
               st_d = FDPC_ST_START;
            end
         end
         FDPC_ST_START, FDPC_ST_RUN: begin
            if (event_any) begin
               short_lat_d = short_lat_q || short_evt;
               ov_lat_d    = ov_lat_q || ov_lock;
               tsd_lat_d   = tsd_lat_q || i_thermal_trip;
               lock_lat_d  = lock_lat_q || i_rotor_locked;
               retry_d     = (retry_q == 4'hf) ? retry_q : retry_q + 4'h1;
               cmd_off_d   = 1'b0;
               tmr_start   = 1'b1;
               st_d        = FDPC_ST_LOCKOUT;
            end else if (sby_done && !i_standby_disable) begin
               st_d = FDPC_ST_STANDBY;
            end else if (st_q == FDPC_ST_START && i_startup_done) begin
               st_d = FDPC_ST_RUN;
            end
         end
         FDPC_ST_LOCKOUT: begin
            if (i_lock_time == LOCK_LATCH) begin
               tmr_clear = 1'b1;
            end
            if (i_retry_limit != RETRY_OFF && retry_q > i_retry_limit) begin
               st_d = FDPC_ST_HALT;
            end else if (short_lat_q && i_cfg[CFG_SHORT_CLEAR_SEL_BIT]) begin
               if (cmd_off_q && !cmd_low) begin
                  short_lat_d = 1'b0;
                  ov_lat_d    = 1'b0;
                  tsd_lat_d   = 1'b0;
                  lock_lat_d  = 1'b0;
                  st_d        = FDPC_ST_START;
               end
            end else if (tmr_done && !ov_raw && !i_thermal_trip) begin
               short_lat_d = 1'b0;
               ov_lat_d    = 1'b0;
               tsd_lat_d   = 1'b0;
               lock_lat_d  = 1'b0;
               st_d        = FDPC_ST_START;
            end else if (tmr_done) begin
               tmr_start = 1'b1;
            end
         end
         FDPC_ST_HALT: begin
            if (cmd_off_q && !cmd_low) begin
               retry_d     = '0;
               short_lat_d = 1'b0;
               ov_lat_d    = 1'b0;
               tsd_lat_d   = 1'b0;
               lock_lat_d  = 1'b0;
               st_d        = FDPC_ST_START;
            end
         end
         default: st_d = FDPC_ST_START;
      endcase
      if (st_d == FDPC_ST_START && st_q != FDPC_ST_START) begin
         cmd_off_d = 1'b0;
      end
   end

   // *****************************************************************
   // PWM, speed pulse and outputs
   // *****************************************************************
   logic [PWM_W-1:0] pwm_cnt_q, pwm_cnt_d;
   logic             pwm_q, pwm_d, cut_q, cut_d;
   logic [2:0]       fg_div_q, fg_div_d;
   logic             fg_q, fg_d;
   logic             drv_q, drv_d;
   logic             sda_oe_n_q, sda_oe_n_d;
   logic             test_oe_n_q, test_oe_n_d;
   logic             fault_n_q, fault_n_d;
   logic             sby_q, sby_d;
   logic             rb_q, rb_d;
   logic             slew_q, slew_d;
   logic [1:0]       slew_cyc_q, slew_cyc_d;
   logic [2:0]       pp;
   logic [3:0]       fg_acc, fg_pairs;

   always_comb begin
      pp        = i_cfg[CFG_PP_LSB +: 3];
      fg_pairs  = {1'b0, pp} + 4'h1;
      fg_acc    = {1'b0, fg_div_q} + 4'h2;
      pwm_cnt_d = (pwm_cnt_q == DMD_MAX - 9'h001) ? '0 : pwm_cnt_q + 9'h001;
      cut_d     = (pwm_cnt_d == '0) ? 1'b0 : (cut_q || (pwm_q && i_current_limit));
      drv_d     = (st_d == FDPC_ST_START || st_d == FDPC_ST_RUN) && !ov_follow;
      pwm_d     = drv_d && (pwm_cnt_d < dmd_d) && !cut_d;
      fg_div_d  = fg_div_q;
      fg_d      = fg_q;
      if (!drv_q) begin
         fg_div_d = '0;
      end else if (i_elec_tick) begin
         // Two per half-period against the pair count keeps odd pair counts exact on average.
         if (fg_acc >= fg_pairs) begin
            fg_div_d = 3'(fg_acc - fg_pairs);
            fg_d     = !fg_q;
         end else begin
            fg_div_d = fg_acc[2:0];
         end
      end
      sda_oe_n_d  = i_i2c_active ? !i_i2c_sda_low : fg_q;
      test_oe_n_d = (st_d == FDPC_ST_RUN);
      fault_n_d   = !(i_vbb_uv || ov_raw && !(i_overvoltage_disable && i_cfg[CFG_OVERVOLTAGE_LOCK_OPT_BIT])
                      || i_thermal_trip || i_pump_uv || lock_lat_d || short_lat_d
                      || ov_lat_d || tsd_lat_d || st_d == FDPC_ST_HALT);
      sby_d       = (st_d == FDPC_ST_STANDBY);
      rb_d        = (i_password == PASSWORD_NONE);
      slew_d      = i_cfg[CFG_SLEW_BIT];
      slew_cyc_d  = slew_d ? 2'(SLEW_SLOW_CYC) : 2'(SLEW_FAST_CYC);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q        <= FDPC_ST_START;
         dmd_q       <= '0;
         short_lat_q <= 1'b0;
         ov_lat_q    <= 1'b0;
         tsd_lat_q   <= 1'b0;
         lock_lat_q  <= 1'b0;
         retry_q     <= '0;
         blank_q     <= '0;
         cmd_off_q   <= 1'b0;
         pwm_cnt_q   <= '0;
         pwm_q       <= 1'b0;
         cut_q       <= 1'b0;
         fg_div_q    <= '0;
         fg_q        <= 1'b1;
         drv_q       <= 1'b0;
         sda_oe_n_q  <= 1'b1;
         test_oe_n_q <= 1'b0;
         fault_n_q   <= 1'b1;
         sby_q       <= 1'b0;
         rb_q        <= 1'b1;
         slew_q      <= 1'b0;
         slew_cyc_q  <= 2'(SLEW_FAST_CYC);
      end else begin
         st_q        <= st_d;
         dmd_q       <= dmd_d;
         short_lat_q <= short_lat_d;
         ov_lat_q    <= ov_lat_d;
         tsd_lat_q   <= tsd_lat_d;
         lock_lat_q  <= lock_lat_d;
         retry_q     <= retry_d;
         blank_q     <= blank_d;
         cmd_off_q   <= cmd_off_d;
         pwm_cnt_q   <= pwm_cnt_d;
         pwm_q       <= pwm_d;
         cut_q       <= cut_d;
         fg_div_q    <= fg_div_d;
         fg_q        <= fg_d;
         drv_q       <= drv_d;
         sda_oe_n_q  <= sda_oe_n_d;
         test_oe_n_q <= test_oe_n_d;
         fault_n_q   <= fault_n_d;
         sby_q       <= sby_d;
         rb_q        <= rb_d;
         slew_q      <= slew_d;
         slew_cyc_q  <= slew_cyc_d;
      end
   end

   // *****************************************************************
   // Output assignment
   // *****************************************************************
   // Open-drain pins drive only low; the enable carries the level.
   assign o_pwm              = pwm_q;
   assign o_drive_en         = drv_q;
   assign o_slew_slow        = slew_q;
   assign o_slew_cycles      = slew_cyc_q;
   assign o_speed_pulse_oe_n = sda_oe_n_q;
   assign o_speed_pulse_out  = 1'b0;
   assign o_startup_oe_n     = test_oe_n_q;
   assign o_startup_out      = 1'b0;
   assign o_fault_out_n      = fault_n_q;
   assign o_standby          = sby_q;
   assign o_readback_ok      = rb_q;
   assign o_demand           = dmd_q;
endmodule : fdpc_ctrl

//--- dv/fdpc_ctrl_asserts.sv
`timescale 1ns/10ps
module fdpc_ctrl_asserts
   import fdpc_pkg::*;
(
   // Watched ports
   input wire logic        i_clk, i_rst_n, i_rotor_locked, i_thermal_trip,
   input wire logic        i_short_circuit_trip, i_switch_on, i_current_limit,
   input wire logic        i_overvoltage_level_sel, i_ov_19v, i_ov_38v, i_vbb_uv, i_pump_uv,
   input wire logic [15:0] i_cfg, i_password,
   input wire logic        o_pwm, o_drive_en, o_slew_slow, o_fault_out_n, o_readback_ok,
   input wire logic [1:0]  o_slew_cycles
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire ov_hit = i_overvoltage_level_sel ? i_ov_38v : i_ov_19v;
   // Short glitches must ride through blanking, so only a long run has to trip.
   sequence s_short; (i_short_circuit_trip && i_switch_on) [*8]; endsequence
   sequence s_cfg_held; $stable(i_cfg) [*3]; endsequence
   chk_lock_stop: assert property (i_rotor_locked && o_drive_en |=> !o_drive_en)
      else $error("rotor lock left drive on");
   chk_heat_stop: assert property (i_thermal_trip && o_drive_en |=> !o_drive_en)
      else $error("thermal trip left drive on");
   chk_uv_fault: assert property (i_vbb_uv || i_pump_uv |=> !o_fault_out_n)
      else $error("undervoltage not flagged");
   chk_short_trip: assert property (s_short ##1 s_short |-> ##[0:2] !o_drive_en)
      else $error("short did not stop drive");
   chk_ov_follow: assert property (
      ov_hit && !i_cfg[CFG_OVERVOLTAGE_LOCK_OPT_BIT] && o_drive_en |=> !o_drive_en)
      else $error("overvoltage left drive on");
   chk_limit_cut: assert property (i_current_limit && o_pwm |-> ##[1:2] !o_pwm)
      else $error("current limit did not cut pulse");
   chk_slew_sel: assert property (
      s_cfg_held |-> {o_slew_slow, o_slew_cycles} == (i_cfg[CFG_SLEW_BIT] ? 3'h6 : 3'h1))
      else $error("slew setting not followed");
   chk_pw_block: assert property (
      (i_password != PASSWORD_NONE) [*2] |=> !o_readback_ok)
      else $error("readback open with password set");
endmodule : fdpc_ctrl_asserts

bind fdpc_ctrl fdpc_ctrl_asserts fdpc_ctrl_asserts_i (.*);

//--- dv/fdpc_host_model.sv
`timescale 1ns/10ps
module fdpc_host_model (
   // Clock and demand shape
   input  wire logic       i_clk,
   input  wire logic       i_run,
   input  wire logic [7:0] i_high,
   input  wire logic [7:0] i_period,
   // Speed demand pin
   output logic            o_speed_demand
);
   int cnt = 0;
   initial o_speed_demand = 1'b0;
   // Stopping holds the pin low, the off half of an off-on command cycle.
   always @(posedge i_clk) begin
      cnt <= (cnt + 1 >= i_period) ? 0 : cnt + 1;
      o_speed_demand <= i_run && cnt < i_high;
   end
endmodule : fdpc_host_model

//--- dv/fan_demand_and_protection_ctrl_test.sv
`timescale 1ns/10ps
module fan_demand_and_protection_ctrl_test;
   import fdpc_pkg::*;
   logic i_clk = 0, i_rst_n = 0, i_i2c_active = 0, i_i2c_dmd_valid = 0, i_elec_tick = 0;
   logic i_overvoltage_disable = 0, i_overvoltage_level_sel = 0, i_standby_disable = 0;
   logic i_startup_done = 0, i_rotor_locked = 0, i_current_limit = 0, i_switch_on = 0;
   logic i_short_circuit_trip = 0, i_ov_19v = 0, i_ov_38v = 0, i_thermal_trip = 0;
   logic i_vbb_uv = 0, i_pump_uv = 0, i_i2c_sda_low = 0, i_speed_demand_in, h_run = 0;
   logic [15:0] i_cfg = 16'h0010, i_password = 16'h0000;
   logic [8:0] i_adc_code = 9'h000, i_i2c_dmd = 9'h000, o_demand;
   logic [7:0] i_lock_time = 8'h01, h_high = 8'h00;
   logic [3:0] i_retry_limit = 4'h0;
   logic [1:0] o_slew_cycles;
   logic o_pwm, o_drive_en, o_slew_slow, o_speed_pulse_oe_n, o_speed_pulse_out;
   logic o_startup_oe_n, o_startup_out, o_fault_out_n, o_standby, o_readback_ok;
   int n_errors = 0, num_checks = 0, v, cnt;
   logic m_fg = 1'b1, m_fg_q = 1'b1;
   int m_acc = 0;
   fdpc_ctrl fdpc_ctrl_i (.*);
   fdpc_host_model fdpc_host_model_i (.i_clk(i_clk), .i_run(h_run), .i_high(h_high),
      .i_period(8'hc8), .o_speed_demand(i_speed_demand_in));
   initial forever #50 i_clk = ~i_clk;
   always @(posedge i_clk) i_elec_tick <= ($urandom_range(0, 7) == 0);
   // Speed pulse model: two counts per electrical half-period against the pair count.
   always @(posedge i_clk) begin
      m_fg_q <= m_fg;
      if (!i_rst_n) begin
         m_fg  <= 1'b1;
         m_acc <= 0;
      end else if (!o_drive_en) begin
         m_acc <= 0;
      end else if (i_elec_tick) begin
         if (m_acc + 2 >= i_cfg[6:4] + 1) begin
            m_acc <= m_acc + 2 - (i_cfg[6:4] + 1);
            m_fg  <= !m_fg;
         end else begin
            m_acc <= m_acc + 2;
         end
      end
   end
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic look(int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask : look
   task automatic do_reset(logic [15:0] cfg);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      i_cfg <= cfg;
      {i_rotor_locked, i_thermal_trip, i_vbb_uv, i_pump_uv, i_startup_done} <= 5'h00;
      {i_switch_on, i_short_circuit_trip, i_ov_19v, i_ov_38v, h_run} <= 5'h01;
      look(10);
      i_rst_n <= 1'b1;
      look(3);
      check("startup pin", o_startup_oe_n, 1'b0);
      check("drive at wake", o_drive_en, 1'b1);
      i_startup_done <= 1'b1;
      look(4);
      check("startup free", o_startup_oe_n, 1'b1);
   endtask : do_reset
   initial begin
      void'($urandom(13140));
      do_reset(16'h0010);
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 199 : (k == 1) ? 1 : $urandom_range(2, 198);
         h_high <= v[7:0];
         look(700);
         check("duty demand", o_demand, 16'(v * 511 / 200));
         cnt = 0;
         repeat (511) begin
            @(negedge i_clk);
            cnt += o_pwm;
         end
         check("pwm duty", 16'(cnt), 16'(v * 511 / 200));
         check("speed pulse", o_speed_pulse_oe_n, m_fg_q);
      end
      v = $urandom_range(0, 511);
      {i_current_limit, i_i2c_active, i_i2c_sda_low, i_i2c_dmd_valid} <= 4'hf;
      i_i2c_dmd <= v[8:0];
      i_password <= 16'(v + 1);
      look(1);
      i_i2c_dmd_valid <= 1'b0;
      look(500);
      check("i2c demand", o_demand, 16'(v));
      check("sda drive", o_speed_pulse_oe_n, 1'b0);
      check("readback lock", o_readback_ok, 1'b0);
      {i_current_limit, i_i2c_active, i_i2c_sda_low, i_password} <= 19'h0;
      look(3);
      check("readback open", o_readback_ok, 1'b1);
      $display("duty and i2c test done");
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 511 : (k == 1) ? 509 : $urandom_range(1, 508);
         i_cfg <= {5'h00, k[0], 10'h018};
         i_adc_code <= v[8:0];
         look(4);
         check("analog demand", o_demand, 16'((v > 509) ? 511 : v + 2));
         check("slew", {o_slew_slow, o_slew_cycles}, k[0] ? 16'h6 : 16'h1);
      end
      $display("analog test done");
      for (int k = 0; k < 4; k++) begin
         do_reset(16'h0010);
         {i_rotor_locked, i_thermal_trip, i_vbb_uv, i_pump_uv} <= 4'h8 >> k;
         look(3);
         check("fault pin", o_fault_out_n, 1'b0);
         if (k < 2) check("lock drive", o_drive_en, 1'b0);
         {i_rotor_locked, i_thermal_trip, i_vbb_uv, i_pump_uv} <= 4'h0;
         look(5);
         check("fault release", o_fault_out_n, 16'(k > 1));
      end
      $display("fault test done");
      for (int k = 0; k < 3; k++) begin
         do_reset(k[1] ? 16'h0210 : 16'h0010);
         {i_overvoltage_disable, i_overvoltage_level_sel} <= 2'(k);
         {i_ov_38v, i_ov_19v} <= k[0] ? 2'h2 : 2'h1;
         look(4);
         check("ov drive", o_drive_en, 16'(k == 2));
         {i_ov_38v, i_ov_19v} <= 2'h0;
         look(4);
         check("ov recover", o_drive_en, 1'b1);
      end
      $display("overvoltage test done");
      do_reset(16'h8010);
      {i_switch_on, i_short_circuit_trip} <= 2'h3;
      look(5);
      check("blanking", o_drive_en, 1'b1);
      look(12);
      check("short trip", o_drive_en, 1'b0);
      {i_switch_on, i_short_circuit_trip, h_run} <= 3'h0;
      look(450);
      h_run <= 1'b1;
      look(450);
      check("short clear", o_drive_en, 1'b1);
      $display("short test done");
      {i_lock_time, i_retry_limit, i_standby_disable, h_high} <= {8'h00, 4'h1, 1'b1, 8'hc8};
      do_reset(16'h0010);
      i_rotor_locked <= 1'b1;
      look(20);
      check("retry fault", o_fault_out_n, 1'b0);
      i_rotor_locked <= 1'b0;
      look(5);
      check("retry halt", o_drive_en, 1'b0);
      h_run <= 1'b0;
      look(3);
      h_run <= 1'b1;
      look(5);
      check("retry resume", o_drive_en, 1'b1);
      check("retry release", o_fault_out_n, 1'b1);
      i_standby_disable <= 1'b0;
      h_run <= 1'b0;
      look(10);
      check("standby on", o_standby, 1'b1);
      check("standby drive", o_drive_en, 1'b0);
      h_run <= 1'b1;
      look(5);
      check("standby off", o_standby, 1'b0);
      $display("retry and standby test done");
      final_report;
   end
   initial begin
      #2000000;
      n_errors++;
      final_report;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
endmodule : fan_demand_and_protection_ctrl_test
